/* File: core/sfram_core.sv */
// Contract
// RULE_01: Chip select high: standby, ignore other inputs, serial output released.
// RULE_02: A new command starts only after a chip select falling edge. A select held low through reset also starts one, as PIN_RST reads it high.
// RULE_03: Input bits taken on serial clock rise, output changes on fall.
// RULE_04: Any serial clock rate up to the maximum, may stop anytime.
// RULE_05: Serial output driven only for read data, released while paused.
// RULE_06: Protect enable set and protect pin low refuses status writes.
// RULE_07: Pause low freezes the operation, ignoring serial clock and select.
// RULE_08: Master changes pause only while serial clock is low.
// RULE_09: Each data byte is committed once its last bit arrives.
// RULE_10: Array holds 8192 uniquely addressable bytes.
// RULE_11: Serial modes 0 and 3 are both accepted.
// RULE_12: Write disable command removes write permission.
// RULE_13: Block protection covers a quarter, a half or the whole array.
// RULE_14: First byte after select is the opcode, then address and data.
// RULE_15: Two address bytes, top three bits ignored, 13-bit address.
// RULE_16: Unknown opcode ignores all input until next select, output released.
// RULE_17: All bytes travel most significant bit first.
// RULE_18: Write enable latch set and cleared by commands gates every write.
`timescale 1ns/1ps
`default_nettype none
module sfram_core (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_si,
	input wire logic spi_hold_n,
	input wire logic spi_wp_n,
	output logic spi_so,
	output logic spi_so_oe,
	output logic standby,
	output logic [7:0] status_q
);
	// ----------------------------------------
	// Pin synchronisers and edge detection.
	// ----------------------------------------
	logic [4:0] s1_ff, s2_ff, s3_ff, lvl_ff, lvd_ff, nxt_lvl;
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s2_ff[i] : lvl_ff[i];
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_ff <= sfram_pkg::PIN_RST;
			s2_ff <= sfram_pkg::PIN_RST;
			s3_ff <= sfram_pkg::PIN_RST;
			lvl_ff <= sfram_pkg::PIN_RST;
			lvd_ff <= sfram_pkg::PIN_RST;
		end else begin
			s1_ff <= {spi_wp_n, spi_hold_n, spi_si, spi_sck, spi_cs_n};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
			lvd_ff <= lvl_ff;
		end
	end
	logic cs_hi, held, rise_sck, fall_sck;
	assign cs_hi = lvl_ff[sfram_pkg::PIN_CS];
	assign held = ~lvl_ff[sfram_pkg::PIN_HOLD];
	assign rise_sck = lvl_ff[sfram_pkg::PIN_SCK] & ~lvd_ff[sfram_pkg::PIN_SCK]; // RULE_11
	assign fall_sck = ~lvl_ff[sfram_pkg::PIN_SCK] & lvd_ff[sfram_pkg::PIN_SCK];

	function automatic logic protected_addr(input logic [1:0] bp, input logic [12:0] a);
		unique case (bp)
			2'h1: protected_addr = (a[12:11] == 2'h3);
			2'h2: protected_addr = a[12];
			2'h3: protected_addr = 1'b1;
			default: protected_addr = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// Command engine.
	// ----------------------------------------
	sfram_pkg::sfram_state_t state_ff, nxt_state;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] sh_ff, nxt_sh, tx_ff, nxt_tx, rx_byte, status_now, mem_q_ff;
	logic [12:0] addr_ff, nxt_addr;
	logic rd_ff, nxt_rd, wel_ff, nxt_wel, status_write_protect_enable_ff, nxt_status_write_protect_enable, so_ff, nxt_so;
	logic drive_ff, nxt_drive, pend_ff, nxt_pend, byte_done, active, outputting;
	logic [1:0] bp_ff, nxt_bp, ld_ff, nxt_ld;
	sfram_pkg::sfram_wr_t pdat_ff, nxt_pdat;
	logic fill_ready;
	assign active = !held && !cs_hi && state_ff != sfram_pkg::SFRAM_IDLE
		&& state_ff != sfram_pkg::SFRAM_IGNORE;
	assign byte_done = active && rise_sck && bit_cnt_ff == 3'h7;
	assign rx_byte = {sh_ff[6:0], lvl_ff[sfram_pkg::PIN_SI]}; // RULE_17
	assign outputting = state_ff == sfram_pkg::SFRAM_READ || state_ff == sfram_pkg::SFRAM_RDSTAT;
	always_comb begin
		status_now = 8'h00;
		status_now[sfram_pkg::ST_STATUS_WRITE_PROTECT_ENABLE_BIT] = status_write_protect_enable_ff;
		status_now[sfram_pkg::ST_BP_HI:sfram_pkg::ST_BP_LO] = bp_ff;
		status_now[sfram_pkg::ST_WEL_BIT] = wel_ff;
	end
	always_comb begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_sh = sh_ff;
		nxt_tx = tx_ff;
		nxt_addr = addr_ff;
		nxt_rd = rd_ff;
		nxt_wel = wel_ff;
		nxt_status_write_protect_enable = status_write_protect_enable_ff;
		nxt_bp = bp_ff;
		nxt_so = so_ff;
		nxt_drive = drive_ff;
		nxt_ld = (ld_ff != 2'h0) ? ld_ff - 2'h1 : 2'h0;
		nxt_pend = pend_ff && !fill_ready;
		nxt_pdat = pdat_ff;
		if (ld_ff == 2'h1) begin
			nxt_tx = mem_q_ff;
			nxt_addr = addr_ff + 13'h0001;
		end
		if (!held) begin // RULE_07
			if (cs_hi) begin // RULE_01
				nxt_state = sfram_pkg::SFRAM_IDLE;
				nxt_bit_cnt = 3'h0;
				nxt_drive = 1'b0;
			end else if (state_ff == sfram_pkg::SFRAM_IDLE) begin
				nxt_state = sfram_pkg::SFRAM_OPCODE; // RULE_02
			end else if (active) begin
				if (rise_sck) begin // RULE_03
					nxt_sh = rx_byte;
					nxt_bit_cnt = bit_cnt_ff + 3'h1;
				end
				if (fall_sck && outputting) begin // RULE_03
					nxt_so = tx_ff[~bit_cnt_ff]; // RULE_17
					nxt_drive = 1'b1;
				end
				if (byte_done) begin
					unique case (state_ff)
						sfram_pkg::SFRAM_OPCODE: begin // RULE_14
							nxt_state = sfram_pkg::SFRAM_IGNORE; // RULE_16
							if (rx_byte == sfram_pkg::OP_WRITE_ENABLE) begin
								nxt_wel = 1'b1; // RULE_18
							end else if (rx_byte == sfram_pkg::OP_WRITE_DISABLE) begin
								nxt_wel = 1'b0; // RULE_12
							end else if (rx_byte == sfram_pkg::OP_READ_STATUS) begin
								nxt_tx = status_now;
								nxt_state = sfram_pkg::SFRAM_RDSTAT;
							end else if (rx_byte == sfram_pkg::OP_WRITE_STATUS) begin
								nxt_state = sfram_pkg::SFRAM_WRSTAT;
							end else if (rx_byte == sfram_pkg::OP_READ
								|| rx_byte == sfram_pkg::OP_WRITE) begin
								nxt_rd = (rx_byte == sfram_pkg::OP_READ);
								nxt_state = sfram_pkg::SFRAM_ADDR_HI;
							end
						end
						sfram_pkg::SFRAM_ADDR_HI: begin
							nxt_addr[12:8] = rx_byte[4:0]; // RULE_15
							nxt_state = sfram_pkg::SFRAM_ADDR_LO;
						end
						sfram_pkg::SFRAM_ADDR_LO: begin
							nxt_addr[7:0] = rx_byte;
							nxt_state = rd_ff ? sfram_pkg::SFRAM_READ : sfram_pkg::SFRAM_WRITE;
							nxt_ld = rd_ff ? sfram_pkg::LOAD_DELAY : 2'h0;
						end
						sfram_pkg::SFRAM_WRITE: begin
							if (wel_ff && !protected_addr(bp_ff, addr_ff)) begin // RULE_13
								nxt_pend = 1'b1; // RULE_09
								nxt_pdat = '{addr: addr_ff, data: rx_byte};
							end
							nxt_addr = addr_ff + 13'h0001;
						end
						sfram_pkg::SFRAM_READ: nxt_ld = sfram_pkg::LOAD_DELAY;
						sfram_pkg::SFRAM_RDSTAT: nxt_tx = status_now;
						sfram_pkg::SFRAM_WRSTAT: begin
							if (wel_ff && !(status_write_protect_enable_ff && !lvl_ff[sfram_pkg::PIN_WP])) begin // RULE_06
								nxt_status_write_protect_enable = rx_byte[sfram_pkg::ST_STATUS_WRITE_PROTECT_ENABLE_BIT];
								nxt_bp = rx_byte[sfram_pkg::ST_BP_HI:sfram_pkg::ST_BP_LO];
							end
							nxt_state = sfram_pkg::SFRAM_IGNORE;
						end
						default: nxt_state = sfram_pkg::SFRAM_IGNORE;
					endcase
				end
			end
		end
	end
	// Reset parks in the ignore state; PIN_RST reads select high, so it goes idle at once and a select already low starts a command.
	always_ff @(posedge mclk or posedge sys_rst) begin // RULE_04
		if (sys_rst) begin
			state_ff <= sfram_pkg::SFRAM_IGNORE;
			bit_cnt_ff <= 3'h0;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			addr_ff <= 13'h0000;
			rd_ff <= 1'b0;
			wel_ff <= sfram_pkg::ST_WEL_RST;
			status_write_protect_enable_ff <= sfram_pkg::ST_STATUS_WRITE_PROTECT_ENABLE_RST;
			bp_ff <= sfram_pkg::ST_BP_RST;
			so_ff <= 1'b0;
			drive_ff <= 1'b0;
			ld_ff <= 2'h0;
			pend_ff <= 1'b0;
			pdat_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			sh_ff <= nxt_sh;
			tx_ff <= nxt_tx;
			addr_ff <= nxt_addr;
			rd_ff <= nxt_rd;
			wel_ff <= nxt_wel;
			status_write_protect_enable_ff <= nxt_status_write_protect_enable;
			bp_ff <= nxt_bp;
			so_ff <= nxt_so;
			drive_ff <= nxt_drive;
			ld_ff <= nxt_ld;
			pend_ff <= nxt_pend;
			pdat_ff <= nxt_pdat;
		end
	end
	assign spi_so = so_ff;
	assign spi_so_oe = drive_ff && outputting && !held && !cs_hi; // RULE_05
	assign standby = cs_hi;
	assign status_q = status_now;

	// ----------------------------------------
	// Two-entry write buffer and array.
	// ----------------------------------------
	sfram_pkg::sfram_wr_t buf_ff [sfram_pkg::BUF_DEPTH];
	sfram_pkg::sfram_wr_t nxt_buf [sfram_pkg::BUF_DEPTH];
	logic wp_ff, nxt_wp, rp_ff, nxt_rp, drain_valid, drain_ready, drain_fire;
	logic [1:0] cnt_ff, nxt_cnt;
	logic [7:0] mem [sfram_pkg::MEM_DEPTH]; // RULE_10
	assign fill_ready = (cnt_ff != 2'h2);
	assign drain_valid = (cnt_ff != 2'h0);
	assign drain_ready = (ld_ff == 2'h0);
	assign drain_fire = drain_valid && drain_ready;
	always_comb begin
		nxt_buf = buf_ff;
		nxt_wp = wp_ff;
		nxt_rp = rp_ff;
		nxt_cnt = cnt_ff;
		if (pend_ff && fill_ready) begin
			nxt_buf[wp_ff] = pdat_ff;
			nxt_wp = ~wp_ff;
		end
		if (drain_fire) begin
			nxt_rp = ~rp_ff;
		end
		nxt_cnt = cnt_ff + {1'b0, pend_ff && fill_ready} - {1'b0, drain_fire};
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			buf_ff <= '{default: '0};
			wp_ff <= 1'b0;
			rp_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			buf_ff <= nxt_buf;
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end
	always_ff @(posedge mclk) begin
		if (drain_fire) begin
			mem[buf_ff[rp_ff].addr] <= buf_ff[rp_ff].data; // RULE_09
		end
		mem_q_ff <= mem[addr_ff];
	end

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	standby_release_a: assert property (cs_hi |-> !spi_so_oe) else $error("output driven in standby"); // RULE_01
	standby_state_a: assert property (cs_hi && !held |=> state_ff == sfram_pkg::SFRAM_IDLE) else $error("not idle in standby"); // RULE_01
	start_after_fall_a: assert property ($rose(state_ff == sfram_pkg::SFRAM_OPCODE) |-> $past(state_ff == sfram_pkg::SFRAM_IDLE) && !cs_hi) else $error("command started without select edge"); // RULE_02
	so_on_fall_a: assert property ($changed(spi_so) |-> $past(fall_sck) && $past(outputting)) else $error("output changed off falling edge"); // RULE_03
	pause_release_a: assert property (held |-> !spi_so_oe) else $error("output driven while paused"); // RULE_05
	status_guard_a: assert property (byte_done && state_ff == sfram_pkg::SFRAM_WRSTAT && status_write_protect_enable_ff && !lvl_ff[sfram_pkg::PIN_WP] |=> $stable(status_write_protect_enable_ff) && $stable(bp_ff)) else $error("protected status written"); // RULE_06
	pause_freeze_a: assert property (held ##1 held |-> $stable(bit_cnt_ff) && $stable(state_ff)) else $error("state moved while paused"); // RULE_07
	byte_commit_a: assert property (byte_done && state_ff == sfram_pkg::SFRAM_WRITE && wel_ff && !protected_addr(bp_ff, addr_ff) |-> ##[1:8] drain_fire) else $error("byte not committed"); // RULE_09
	write_disable_a: assert property (byte_done && state_ff == sfram_pkg::SFRAM_OPCODE && rx_byte == sfram_pkg::OP_WRITE_DISABLE |=> !wel_ff ##1 !wel_ff) else $error("write latch not cleared"); // RULE_12
	block_guard_a: assert property (byte_done && state_ff == sfram_pkg::SFRAM_WRITE && protected_addr(bp_ff, addr_ff) && !pend_ff |=> !pend_ff) else $error("protected byte queued"); // RULE_13
	bad_opcode_a: assert property (byte_done && state_ff == sfram_pkg::SFRAM_OPCODE && rx_byte == 8'hff |=> state_ff == sfram_pkg::SFRAM_IGNORE) else $error("unknown opcode not ignored"); // RULE_16
	no_wel_write_a: assert property (byte_done && state_ff == sfram_pkg::SFRAM_WRITE && !wel_ff && !pend_ff |=> !pend_ff) else $error("write without permission"); // RULE_18
endmodule // sfram_core
`default_nettype wire

/* File: core/sfram_pkg.sv */
`default_nettype none
package sfram_pkg;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned MEM_DEPTH = 8192;
	localparam int unsigned BUF_DEPTH = 2;
	// ----------------------------------------
	// Pin positions in the synchronised vector.
	// ----------------------------------------
	localparam int unsigned PIN_CS = 0;
	localparam int unsigned PIN_SCK = 1;
	localparam int unsigned PIN_SI = 2;
	localparam int unsigned PIN_HOLD = 3;
	localparam int unsigned PIN_WP = 4;
	localparam logic [4:0] PIN_RST = 5'h1f;
	// ----------------------------------------
	// Command codes.
	// ----------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	// ----------------------------------------
	// Status layout and reset values.
	// ----------------------------------------
	localparam int unsigned ST_STATUS_WRITE_PROTECT_ENABLE_BIT = 7;
	localparam int unsigned ST_BP_HI = 3;
	localparam int unsigned ST_BP_LO = 2;
	localparam int unsigned ST_WEL_BIT = 1;
	localparam logic ST_STATUS_WRITE_PROTECT_ENABLE_RST = 1'b0;
	localparam logic [1:0] ST_BP_RST = 2'h0;
	localparam logic ST_WEL_RST = 1'b0;
	localparam logic [1:0] LOAD_DELAY = 2'h2;
	typedef struct packed {
		logic [12:0] addr;
		logic [7:0] data;
	} sfram_wr_t;
	typedef enum logic [8:0] {
		SFRAM_IDLE = 9'h001,
		SFRAM_OPCODE = 9'h002,
		SFRAM_ADDR_HI = 9'h004,
		SFRAM_ADDR_LO = 9'h008,
		SFRAM_WRITE = 9'h010,
		SFRAM_READ = 9'h020,
		SFRAM_RDSTAT = 9'h040,
		SFRAM_WRSTAT = 9'h080,
		SFRAM_IGNORE = 9'h100
	} sfram_state_t;
endpackage
`default_nettype wire

/* File: testbench/sfram_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sfram_spi_master (
	input wire logic mclk,
	output logic spi_cs_n,
	output logic spi_sck,
	output logic spi_si,
	output logic spi_hold_n,
	output logic spi_wp_n,
	input wire logic spi_so,
	input wire logic spi_so_oe
);
	// ----------------------------------------
	// Serial clock of 160 ns, made of 20 ns steps.
	// ----------------------------------------
	localparam int HALF = 4;
	logic mode3;
	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		spi_si = 1'b0;
		spi_hold_n = 1'b1;
		spi_wp_n = 1'b1;
		mode3 = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic start(input logic m3);
		mode3 = m3;
		spi_sck = m3;
		tick(HALF);
		spi_cs_n = 1'b0;
		tick(HALF);
	endtask
	// A released output is seen as the inverse of its last level.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_sck = 1'b0;
			spi_si = tx[i];
			tick(HALF);
			spi_sck = 1'b1;
			tick(HALF - 1);
			rx[i] = spi_so_oe ? spi_so : ~spi_so;
			tick(1);
		end
	endtask
	task automatic stop;
		spi_sck = mode3;
		tick(HALF);
		spi_cs_n = 1'b1;
		tick(2 * HALF);
		spi_si = ~spi_si;
	endtask
	task automatic pause(input int n, output logic oe_hi);
		oe_hi = 1'b0;
		spi_sck = 1'b0;
		tick(HALF);
		spi_hold_n = 1'b0;
		tick(HALF);
		repeat (n) begin
			oe_hi = oe_hi | spi_so_oe;
			spi_sck = 1'b1;
			spi_si = ~spi_si;
			tick(HALF);
			oe_hi = oe_hi | spi_so_oe;
			spi_sck = 1'b0;
			tick(HALF);
		end
		spi_hold_n = 1'b1;
		tick(HALF);
	endtask
	task automatic set_wp(input logic v);
		spi_wp_n = v;
		tick(HALF);
	endtask
endmodule // sfram_spi_master
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic spi_cs_n, spi_sck, spi_si, spi_hold_n, spi_wp_n, spi_so, spi_so_oe, standby;
	logic [7:0] status_q;
	logic [7:0] rx;
	logic oe_seen = 1'b0;
	int fail_count = 0;
	int compares = 0;
	always #10 mclk = ~mclk;
	always @(negedge mclk) if (spi_so_oe === 1'b1) oe_seen <= 1'b1;
	sfram_core i_sfram_core (.mclk(mclk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
		.spi_sck(spi_sck), .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe), .standby(standby), .status_q(status_q));
	sfram_spi_master i_sfram_spi_master (.mclk(mclk), .spi_cs_n(spi_cs_n),
		.spi_sck(spi_sck), .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic frame(input logic m3, input logic [7:0] b [$], output logic [7:0] last);
		i_sfram_spi_master.start(m3);
		foreach (b[i]) i_sfram_spi_master.xfer(b[i], last);
		i_sfram_spi_master.stop();
	endtask
	task automatic s_reset;
		check("standby", {7'h00, standby}, 8'h01);
		check("status", status_q, 8'h00);
		check("so_oe", {7'h00, spi_so_oe}, 8'h00);
	endtask
	task automatic s_write_read;
		logic [7:0] exp [3];
		exp = '{8'h5a, 8'hc3, 8'h81};
		frame(1'b0, '{8'h06}, rx);
		frame(1'b0, '{8'h02, 8'hff, 8'hfe, 8'h5a, 8'hc3, 8'h81}, rx);
		i_sfram_spi_master.start(1'b1);
		i_sfram_spi_master.xfer(8'h03, rx);
		i_sfram_spi_master.xfer(8'h1f, rx);
		i_sfram_spi_master.xfer(8'hfe, rx);
		for (int i = 0; i < 3; i++) begin
			i_sfram_spi_master.xfer(8'h00, rx);
			check("burst", rx, exp[i]);
		end
		i_sfram_spi_master.stop();
		frame(1'b0, '{8'h03, 8'he0, 8'h00, 8'h00}, rx);
		check("top_bits", rx, 8'h81);
	endtask
	task automatic s_protect;
		frame(1'b0, '{8'h06}, rx);
		frame(1'b0, '{8'h01, 8'h84}, rx);
		check("status_set", status_q, 8'h86);
		frame(1'b0, '{8'h02, 8'h1f, 8'hff, 8'h00}, rx);
		frame(1'b0, '{8'h03, 8'h1f, 8'hff, 8'h00}, rx);
		check("protected", rx, 8'hc3);
		frame(1'b0, '{8'h02, 8'h00, 8'h01, 8'h22}, rx);
		frame(1'b1, '{8'h03, 8'h00, 8'h01, 8'h00}, rx);
		check("open", rx, 8'h22);
		i_sfram_spi_master.set_wp(1'b0);
		frame(1'b0, '{8'h01, 8'h00}, rx);
		check("wp_lock", status_q, 8'h86);
		i_sfram_spi_master.set_wp(1'b1);
		frame(1'b0, '{8'h01, 8'h00}, rx);
		check("wp_free", status_q, 8'h02);
		frame(1'b1, '{8'h02, 8'h10, 8'h00, 8'h44}, rx);
		frame(1'b1, '{8'h01, 8'h08}, rx);
		check("half_set", status_q, 8'h0a);
		frame(1'b1, '{8'h02, 8'h10, 8'h00, 8'h66}, rx);
		frame(1'b0, '{8'h03, 8'h10, 8'h00, 8'h00}, rx);
		check("half", rx, 8'h44);
		frame(1'b0, '{8'h01, 8'h0c}, rx);
		check("all_set", status_q, 8'h0e);
		frame(1'b0, '{8'h02, 8'h00, 8'h01, 8'h77}, rx);
		frame(1'b0, '{8'h03, 8'h00, 8'h01, 8'h00}, rx);
		check("whole", rx, 8'h22);
		frame(1'b0, '{8'h01, 8'h00}, rx);
		check("open_set", status_q, 8'h02);
		frame(1'b0, '{8'h04}, rx);
		check("disabled", status_q, 8'h00);
		frame(1'b0, '{8'h02, 8'h00, 8'h01, 8'h33}, rx);
		frame(1'b0, '{8'h03, 8'h00, 8'h01, 8'h00}, rx);
		check("no_latch", rx, 8'h22);
		frame(1'b1, '{8'h06}, rx);
		frame(1'b1, '{8'h05, 8'h00}, rx);
		check("status_rd", rx, 8'h02);
	endtask
	task automatic s_bad;
		oe_seen = 1'b0;
		frame(1'b0, '{8'hff, 8'h03, 8'h00, 8'h01, 8'h00}, rx);
		check("bad_oe", {7'h00, oe_seen}, 8'h00);
		check("standby_end", {7'h00, standby}, 8'h01);
		frame(1'b0, '{8'h03, 8'h00, 8'h01, 8'h00}, rx);
		check("after_bad", rx, 8'h22);
	endtask
	task automatic s_hold;
		logic oe_hi;
		i_sfram_spi_master.start(1'b0);
		i_sfram_spi_master.xfer(8'h03, rx);
		i_sfram_spi_master.xfer(8'h00, rx);
		i_sfram_spi_master.xfer(8'h00, rx);
		i_sfram_spi_master.xfer(8'h00, rx);
		check("hold_pre", rx, 8'h81);
		check("hold_drv", {7'h00, spi_so_oe}, 8'h01);
		check("selected", {7'h00, standby}, 8'h00);
		i_sfram_spi_master.pause(6, oe_hi);
		check("hold_oe", {7'h00, oe_hi}, 8'h00);
		i_sfram_spi_master.xfer(8'h00, rx);
		i_sfram_spi_master.stop();
		check("hold_rd", rx, 8'h22);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		s_reset();
		s_write_read();
		s_protect();
		s_bad();
		s_hold();
		summarize();
	end
	initial begin
		repeat (100000) @(posedge mclk);
		fail_count++;
		summarize();
	end
endmodule // testbench
`default_nettype wire
